// File: core/bdc_pkg.sv
// package for the batch dosing controller: register map, fields, timing
// assumes a 20 MHz system clock and a classic wishbone register bus
package bdc_pkg;
  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned KEY_HOLD_MS   = 2000;
  localparam int unsigned PULSE_MIN_MS  = 500;
  localparam int unsigned PULSE_MAX_MS  = 4000;
  localparam int unsigned RESET_MIN_MS  = 5000;
  localparam int unsigned TMO_MIN_DS    = 5;
  localparam int unsigned TMO_MAX_DS    = 100;
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_QTY    = 8'h04;
  localparam logic [7:0] ADDR_CORR   = 8'h08;
  localparam logic [7:0] ADDR_UNIT   = 8'h0c;
  localparam logic [7:0] ADDR_TMO    = 8'h10;
  localparam logic [7:0] ADDR_STAT   = 8'h14;
  localparam logic [7:0] ADDR_IRQ    = 8'h18;
  localparam logic [7:0] ADDR_MASK   = 8'h1c;
  localparam logic [7:0] ADDR_COUNT  = 8'h20;
  localparam logic [7:0] ADDR_PCT    = 8'h24;
  // ==========================================================================
  // fields and values
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam logic [16:0] QTY_MAX       = 17'h1869f;
  localparam logic [16:0] QTY_RST       = 17'h00000;
  localparam logic [16:0] CORR_RST      = 17'h00000;
  localparam logic [2:0]  UNIT_RST      = 3'h1;
  localparam logic [6:0]  TMO_RST       = 7'h05;
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_TMO       = 0;
  localparam int unsigned IRQ_DONE      = 1;
  localparam int unsigned IRQ_WARN      = 2;
  localparam int unsigned IRQ_IGN       = 3;

  typedef enum logic [2:0] {UNIT_ML, UNIT_L, UNIT_M3, UNIT_GALUS, UNIT_GALUK,
                            UNIT_BARREL, UNIT_USER} bdc_unit_t;
  typedef enum {ST_OFF, ST_STOP, ST_RUN, ST_DONE} bdc_state_t;
  typedef enum logic [1:0] {CMD_NONE, CMD_STARTSTOP, CMD_RESET} bdc_cmd_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } bdc_wb_req_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic reset;
  } bdc_keys_t;
endpackage : bdc_pkg

// File: core/bdc_hold_key.sv
// long-press detector: one pulse when a key held long enough is released
// assumes the key input is already synchronised to clk_i
`timescale 1ns/1ps
module bdc_hold_key
  import bdc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = KEY_HOLD_MS * MS_CYC
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic key_i,
  output logic      fire_o
);
  if (HOLD_CYC < 1)
  begin : g_bad_hold
    $error("hold count must be at least one");
  end
  logic [31:0] cnt_reg;
  logic        key_d_reg;
  // ==========================================================================
  // hold counter saturates so a very long press still fires
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg   <= 32'h0;
      key_d_reg <= 1'b0;
      fire_o    <= 1'b0;
    end
    else
    begin
      key_d_reg <= key_i;
      fire_o    <= key_d_reg && !key_i && (cnt_reg >= HOLD_CYC);
      if (!key_i)
        cnt_reg <= 32'h0;
      else if (cnt_reg < HOLD_CYC)
        cnt_reg <= cnt_reg + 32'h1;
    end
  end

  AST_SHORT_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
    fire_o |-> $past(cnt_reg, 1) >= HOLD_CYC)
    else $error("key fired after a short press");
endmodule : bdc_hold_key

// File: core/bdc_pulse_meas.sv
// measures high time of the synchronised control line, classifies on release
// assumes ctl_i passed a two-flop synchroniser in the parent
`timescale 1ns/1ps
module bdc_pulse_meas
  import bdc_pkg::*;
#(
  parameter int unsigned MIN_CYC = PULSE_MIN_MS * MS_CYC,
  parameter int unsigned MAX_CYC = PULSE_MAX_MS * MS_CYC,
  parameter int unsigned RST_CYC = RESET_MIN_MS * MS_CYC
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ctl_i,
  output bdc_cmd_t  cmd_o
);
  if (!(MIN_CYC < MAX_CYC && MAX_CYC < RST_CYC))
  begin : g_bad_windows
    $error("bad pulse windows");
  end
  logic [31:0] cnt_reg;
  logic        ctl_d_reg;
  // ==========================================================================
  // strict bounds at both ends; the gap 4..5 s yields nothing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg   <= 32'h0;
      ctl_d_reg <= 1'b0;
      cmd_o     <= CMD_NONE;
    end
    else
    begin
      ctl_d_reg <= ctl_i;
      cmd_o     <= CMD_NONE;
      if (ctl_d_reg && !ctl_i)
      begin
        if (cnt_reg > MIN_CYC && cnt_reg < MAX_CYC)
          cmd_o <= CMD_STARTSTOP;
        else if (cnt_reg > RST_CYC)
          cmd_o <= CMD_RESET;
      end
      if (!ctl_i)
        cnt_reg <= 32'h0;
      else if (cnt_reg <= RST_CYC)
        cnt_reg <= cnt_reg + 32'h1;
    end
  end

  AST_PULSE_WINDOW: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_o == CMD_STARTSTOP |-> $past(cnt_reg, 1) > MIN_CYC)
    else $error("start/stop from too short pulse");
endmodule : bdc_pulse_meas

// File: core/bdc_top.sv
// batch dosing controller: run state, dosing counter, wishbone registers
// assumes flow pulses and keys arrive from other clock domains; single clk_i
// Functional notes
// - when enabled, second line is dosing output, first line is control input
// - on disable both lines deactivated, free for other functions afterwards
// - softkey fires only after a hold of two seconds then release
// - start from key or 0.5..4 s control pulse, only when stopped or done
// - running: stop key or 0.5..4 s pulse stops or pauses
// - stopped or done: reset key or >5 s pulse restores the preset
// - on start dosing output goes high; counter counts down with flow
// - restart after pause resumes from the remaining quantity
// - quantity kept in tenths, limited to 9999.9
// - unit selector: ml, l, m3, gal us, gal uk, barrel, user
// - counter stops at negated correction so dispensed equals preset plus it
// - preset plus correction not above zero: warn, force correction
// - zero flow for the timeout during a run raises timeout status
// - timeout configurable 0.5 s to 10 s
// - progress percentage computed, including overfill above hundred
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module bdc_top
  import bdc_pkg::*;
#(
  parameter int unsigned KEY_CYC   = KEY_HOLD_MS * MS_CYC,
  parameter int unsigned PMIN_CYC  = PULSE_MIN_MS * MS_CYC,
  parameter int unsigned PMAX_CYC  = PULSE_MAX_MS * MS_CYC,
  parameter int unsigned PRST_CYC  = RESET_MIN_MS * MS_CYC,
  parameter int unsigned DS_CYC    = CLK_HZ / 10
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        key_start_i,
  input  wire logic        key_stop_i,
  input  wire logic        key_reset_i,
  input  wire logic        first_output_line_i,
  output logic             first_output_line_o,
  output logic             first_output_line_oe_o,
  output logic             second_output_line_o,
  output logic             second_output_line_oe_o,
  input  wire logic        flow_tick_i,
  output logic             irq_o
);
  if (DS_CYC < 1)
  begin : g_bad_ds
    $error("tenth-second count must be at least one");
  end
  // ==========================================================================
  // synchronisers, first stage read only by the second
  logic [4:0] s1_reg;
  logic [4:0] s2_reg;
  logic       flow_d_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= 5'h0;
      s2_reg <= 5'h0;
      flow_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= {flow_tick_i, first_output_line_i, key_reset_i, key_stop_i, key_start_i};
      s2_reg <= s1_reg;
      flow_d_reg <= s2_reg[4];
    end
  end
  wire logic flow_pulse = s2_reg[4] && !flow_d_reg;

  // ==========================================================================
  // registers
  logic               en_reg;
  logic signed [17:0] qty_reg;
  logic signed [17:0] corr_reg;
  bdc_unit_t          unit_reg;
  logic [6:0]         tmo_reg;
  logic signed [18:0] count_reg;
  logic [IRQ_W-1:0]   irq_stat_reg;
  logic [IRQ_W-1:0]   irq_mask_reg;
  logic [31:0]        pct_reg;
  bdc_state_t         state_reg;
  bdc_keys_t          key_fire;
  bdc_cmd_t           ctl_cmd;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_key
      bdc_hold_key #(.HOLD_CYC(KEY_CYC)) u_key (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .key_i  (s2_reg[g] && en_reg),
        .fire_o (key_fire[2-g])
      );
    end
  endgenerate

  bdc_pulse_meas #(.MIN_CYC(PMIN_CYC), .MAX_CYC(PMAX_CYC), .RST_CYC(PRST_CYC)) u_meas (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctl_i (s2_reg[3] && en_reg),
    .cmd_o (ctl_cmd)
  );

  // writes land on the edge at which the master samples ack
  function automatic logic hit(input logic [7:0] a);
    hit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_adr_i == a;
  endfunction : hit
  wire logic wr = wb_we_i && wb_sel_i[0];

  // stop point: negated correction
  wire logic signed [18:0] stop_pt = -19'(corr_reg);
  wire logic go    = (state_reg == ST_STOP || state_reg == ST_DONE)
                     && (key_fire.start || ctl_cmd == CMD_STARTSTOP);
  wire logic halt  = state_reg == ST_RUN
                     && (key_fire.stop || ctl_cmd == CMD_STARTSTOP);
  wire logic rst_q = (state_reg == ST_STOP || state_reg == ST_DONE)
                     && (key_fire.reset || ctl_cmd == CMD_RESET);
  wire logic reach = state_reg == ST_RUN && flow_pulse && count_reg - 19'sd1 <= stop_pt;
  wire logic bad_sum = 19'(qty_reg) + 19'(corr_reg) <= 19'sd0;
  wire logic ign   = ctl_cmd != CMD_NONE && !go && !halt && !rst_q;

  // ==========================================================================
  // run state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= ST_OFF;
    else if (!en_reg)
      state_reg <= ST_OFF;
    else if (state_reg == ST_OFF)
      state_reg <= ST_STOP;
    else if (go)
      state_reg <= ST_RUN;
    else if (halt)
      state_reg <= ST_STOP;
    else if (reach)
      state_reg <= ST_DONE;
  end

  // pin roles fixed by enable; disabled lines are released
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      first_output_line_o     <= 1'b0;
      first_output_line_oe_o  <= 1'b0;
      second_output_line_o    <= 1'b0;
      second_output_line_oe_o <= 1'b0;
    end
    else
    begin
      first_output_line_o     <= 1'b0;
      first_output_line_oe_o  <= 1'b0;
      second_output_line_oe_o <= en_reg;
      second_output_line_o    <= en_reg && (go || (state_reg == ST_RUN && !halt && !reach));
    end
  end

  // ==========================================================================
  // dosing counter, tenths of a unit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_reg <= 19'sd0;
    else if (state_reg == ST_OFF || rst_q)
      count_reg <= 19'(qty_reg);
    else if (state_reg == ST_RUN && flow_pulse && !reach)
      count_reg <= count_reg - 19'sd1;
    else if (reach)
      count_reg <= stop_pt;
  end

  // progress: dispensed over target, can exceed 100
  logic signed [18:0] done_amt;
  logic signed [18:0] tgt;
  assign done_amt = 19'(qty_reg) - count_reg;
  assign tgt      = 19'(qty_reg) + 19'(corr_reg);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pct_reg <= 32'h0;
    else if (tgt > 19'sd0 && done_amt >= 19'sd0)
      pct_reg <= 32'((32'(done_amt) * 32'd100) / 32'(tgt));
    else
      pct_reg <= 32'h0;
  end

  // ==========================================================================
  // no-flow timeout, counted in tenths of a second
  logic [31:0] ds_cnt_reg;
  logic [6:0]  idle_reg;
  wire logic   ds_tick = ds_cnt_reg >= DS_CYC - 1;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_reg != ST_RUN || flow_pulse)
    begin
      ds_cnt_reg <= 32'h0;
      idle_reg   <= 7'h0;
    end
    else if (ds_tick)
    begin
      ds_cnt_reg <= 32'h0;
      if (idle_reg < tmo_reg)
        idle_reg <= idle_reg + 7'h1;
    end
    else
      ds_cnt_reg <= ds_cnt_reg + 32'h1;
  end
  wire logic tmo_ev = state_reg == ST_RUN && ds_tick && !flow_pulse
                      && idle_reg + 7'h1 == tmo_reg;

  // ==========================================================================
  // configuration registers
  logic [16:0] wq;
  // clamp on the whole word so large values do not wrap below the limit
  assign wq = wb_dat_i > 32'(QTY_MAX) ? QTY_MAX : wb_dat_i[16:0];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_reg   <= 1'b0;
      qty_reg  <= 18'(QTY_RST);
      unit_reg <= bdc_unit_t'(UNIT_RST);
      tmo_reg  <= TMO_RST;
    end
    else if (wr)
    begin
      if (hit(ADDR_CTRL))
        en_reg <= wb_dat_i[CTRL_EN_BIT];
      if (hit(ADDR_QTY))
        qty_reg <= {1'b0, wq};
      if (hit(ADDR_UNIT) && wb_dat_i[2:0] != 3'h7)
        unit_reg <= bdc_unit_t'(wb_dat_i[2:0]);
      if (hit(ADDR_TMO))
        tmo_reg <= wb_dat_i < 32'(TMO_MIN_DS) ? 7'(TMO_MIN_DS)
                 : wb_dat_i > 32'(TMO_MAX_DS) ? 7'(TMO_MAX_DS) : wb_dat_i[6:0];
    end
  end

  // correction forced to 0.1 - quantity whenever the sum is not positive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      corr_reg <= 18'(CORR_RST);
    else if (wr && hit(ADDR_CORR))
      corr_reg <= wb_dat_i[17:0];
    else if (bad_sum)
      corr_reg <= 18'sd1 - qty_reg;
  end

  // ==========================================================================
  // interrupts: set wins over write-one clear
  logic [IRQ_W-1:0] ev;
  assign ev = {ign, bad_sum, reach, tmo_ev};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_o        <= 1'b0;
    end
    else
    begin
      if (wr && hit(ADDR_IRQ))
        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[IRQ_W-1:0]) | ev;
      else
        irq_stat_reg <= irq_stat_reg | ev;
      if (wr && hit(ADDR_MASK))
        irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================================
  // wishbone slave: ack one cycle after strobe; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      unique case (wb_adr_i)
        ADDR_CTRL:  wb_dat_o <= {30'h0, state_reg == ST_RUN, en_reg};
        ADDR_QTY:   wb_dat_o <= 32'(qty_reg);
        ADDR_CORR:  wb_dat_o <= 32'(corr_reg);
        ADDR_UNIT:  wb_dat_o <= {29'h0, unit_reg};
        ADDR_TMO:   wb_dat_o <= {25'h0, tmo_reg};
        ADDR_STAT:  wb_dat_o <= {30'h0, 2'(state_reg)};
        ADDR_IRQ:   wb_dat_o <= {28'h0, irq_stat_reg};
        ADDR_MASK:  wb_dat_o <= {28'h0, irq_mask_reg};
        ADDR_COUNT: wb_dat_o <= 32'(count_reg);
        ADDR_PCT:   wb_dat_o <= pct_reg;
        default:    wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // checks
  AST_ROLES: assert property (@(posedge clk_i) disable iff (rst_i)
    en_reg |=> second_output_line_oe_o && !first_output_line_oe_o)
    else $error("dosing roles not held");
  AST_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_reg |=> !second_output_line_oe_o && !second_output_line_o)
    else $error("outputs not deactivated");
  AST_START: assert property (@(posedge clk_i) disable iff (rst_i)
    go && en_reg |=> state_reg == ST_RUN && second_output_line_o)
    else $error("start not taken");
  AST_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
    halt && en_reg |=> state_reg == ST_STOP ##1 !second_output_line_o)
    else $error("stop not taken");
  AST_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    rst_q && en_reg |=> count_reg == $past(19'(qty_reg)))
    else $error("preset not restored");
  AST_RESUME: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_STOP && $past(state_reg) == ST_STOP && !rst_q && en_reg
    |=> count_reg == $past(count_reg))
    else $error("count lost while paused");
  AST_QTY_MAX: assert property (@(posedge clk_i) disable iff (rst_i)
    qty_reg <= 18'(QTY_MAX))
    else $error("quantity over limit");
  AST_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
    reach && en_reg |=> state_reg == ST_DONE && count_reg == $past(stop_pt))
    else $error("stop point missed");
  AST_CORR_FIX: assert property (@(posedge clk_i) disable iff (rst_i)
    bad_sum && !(wr && hit(ADDR_CORR)) |=> irq_stat_reg[IRQ_WARN])
    else $error("warning not raised");
  AST_TMO_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    tmo_reg >= 7'(TMO_MIN_DS) && tmo_reg <= 7'(TMO_MAX_DS))
    else $error("timeout out of range");
  AST_TMO_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    tmo_ev |=> irq_stat_reg[IRQ_TMO])
    else $error("timeout flag not set");
  COV_RUN: cover property (@(posedge clk_i) go ##[1:1000] halt);
  COV_DONE: cover property (@(posedge clk_i) reach);
  COV_TMO: cover property (@(posedge clk_i) tmo_ev);
  COV_RST: cover property (@(posedge clk_i) rst_q);
endmodule : bdc_top

// File: verif/bdc_far_model.sv
// far-side model: control line driver, softkeys and flow pulse source
// assumes the bench calls its tasks from the clk_i domain, one at a time
`timescale 1ns/1ps
module bdc_far_model
  import bdc_pkg::*;
(
  input  wire logic clk_i,
  output logic      ctl_o,
  output bdc_keys_t keys_o,
  output logic      flow_o
);
  // ==========================================================================
  // idle levels
  initial
  begin
    ctl_o  = 1'b0;
    keys_o = '0;
    flow_o = 1'b0;
  end

  // ==========================================================================
  // stimulus
  // control line only ever toggles between driven levels, never released
  task automatic pulse(input int n);
    @(posedge clk_i);
    ctl_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    ctl_o <= 1'b0;
  endtask : pulse

  task automatic press(input int k, input int n);
    @(posedge clk_i);
    keys_o[k] <= 1'b1;
    repeat (n) @(posedge clk_i);
    keys_o[k] <= 1'b0;
  endtask : press

  // three cycles high and four low so the synchroniser sees every edge
  task automatic flow(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      flow_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      flow_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : flow
endmodule : bdc_far_model

// File: verif/batch_dosing_controller_bench.sv
// self-checking bench for the batch dosing controller over wishbone
// assumes shortened timing parameters and the far-side model on the pins
`timescale 1ns/1ps
module batch_dosing_controller_bench
  import bdc_pkg::*;
;
  bdc_wb_req_t req;
  logic [3:0]  wsel;
  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic [31:0] rdat;
  logic [31:0] rv;
  logic        ack, l1_o, l1_oe, l2_o, l2_oe, irq, ctl, flow;
  bdc_keys_t   keys;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          cyc_cnt    = 0;

  always #25 clk_i = ~clk_i;

  bdc_top #(.KEY_CYC(20), .PMIN_CYC(10), .PMAX_CYC(40), .PRST_CYC(50), .DS_CYC(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .key_start_i(keys.start), .key_stop_i(keys.stop),
    .key_reset_i(keys.reset), .first_output_line_i(ctl), .first_output_line_o(l1_o),
    .first_output_line_oe_o(l1_oe), .second_output_line_o(l2_o),
    .second_output_line_oe_o(l2_oe), .flow_tick_i(flow), .irq_o(irq));

  bdc_far_model far (.clk_i(clk_i), .ctl_o(ctl), .keys_o(keys), .flow_o(flow));

  // ==========================================================================
  // reporting
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  // ==========================================================================
  // bus access: hold the request until ack is sampled, then two idle cycles
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: wsel, dat: d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rv = rdat;
    req <= '0;
    repeat (2) @(posedge clk_i);
  endtask : bus

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_reg(nm, e, rv & m);
  endtask : rd_chk

  // state changes lag the pins by the synchronisers, so poll a bounded time
  task automatic wait_st(input logic [31:0] e);
    for (int i = 0; i < 30; i++)
    begin
      bus(1'b0, ADDR_STAT, 32'h0);
      if (rv[1:0] === e[1:0])
        break;
    end
    chk_reg("state", e, rv & 32'h3);
  endtask : wait_st

  // ==========================================================================
  // watchdog
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      bad_count++;
      final_report();
    end
  end

  // ==========================================================================
  // tests
  initial
  begin
    req  <= '0;
    wsel <= 4'hf;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl", ADDR_CTRL, 32'h3, 32'h0);
    rd_chk("tmo rst", ADDR_TMO, 32'h7f, {25'h0, TMO_RST});
    rd_chk("unmapped", 8'h30, 32'hffffffff, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h1);
    chk_bit("dose oe", 1'b1, l2_oe);
    chk_bit("ctl oe", 1'b0, l1_oe);
    chk_bit("ctl out", 1'b0, l1_o);
    wait_st(32'h1);
    bus(1'b1, ADDR_QTY, 32'h186a0);
    rd_chk("qty max", ADDR_QTY, 32'h1ffff, {15'h0, QTY_MAX});
    wsel = 4'he;
    bus(1'b1, ADDR_QTY, 32'd7);
    wsel = 4'hf;
    rd_chk("qty sel", ADDR_QTY, 32'h1ffff, {15'h0, QTY_MAX});
    bus(1'b1, ADDR_QTY, 32'd20);
    bus(1'b1, ADDR_CORR, 32'h0);
    far.press(0, 25);
    repeat (6) @(posedge clk_i);
    rd_chk("preset", ADDR_COUNT, 32'hffff, 32'd20);
    for (int u = 0; u < 8; u++)
    begin
      bus(1'b1, ADDR_UNIT, 32'(u));
      rd_chk("unit", ADDR_UNIT, 32'h7, (u == 7) ? 32'h6 : 32'(u));
    end
    bus(1'b1, ADDR_TMO, 32'd2);
    rd_chk("tmo min", ADDR_TMO, 32'h7f, 32'd5);
    bus(1'b1, ADDR_TMO, 32'd200);
    rd_chk("tmo max", ADDR_TMO, 32'h7f, 32'd100);
    bus(1'b1, ADDR_TMO, 32'd5);
    bus(1'b1, ADDR_MASK, 32'hf);
    bus(1'b1, ADDR_IRQ, 32'hf);
    far.pulse(5);
    far.press(2, 10);
    repeat (10) @(posedge clk_i);
    wait_st(32'h1);
    rd_chk("short ignored", ADDR_IRQ, 32'h8, 32'h0);
    bus(1'b1, ADDR_IRQ, 32'hf);
    far.pulse(20);
    wait_st(32'h2);
    chk_bit("dose out", 1'b1, l2_o);
    repeat (60) @(posedge clk_i);
    rd_chk("timeout", ADDR_IRQ, 32'h1, 32'h1);
    chk_bit("irq", 1'b1, irq);
    far.pulse(45);
    repeat (10) @(posedge clk_i);
    wait_st(32'h2);
    far.pulse(60);
    repeat (10) @(posedge clk_i);
    rd_chk("ignored", ADDR_IRQ, 32'h8, 32'h8);
    wait_st(32'h2);
    far.flow(5);
    rd_chk("count", ADDR_COUNT, 32'hffff, 32'd15);
    rd_chk("percent", ADDR_PCT, 32'h3ff, 32'd25);
    far.press(1, 25);
    wait_st(32'h1);
    chk_bit("dose out", 1'b0, l2_o);
    far.flow(2);
    rd_chk("count", ADDR_COUNT, 32'hffff, 32'd15);
    far.press(2, 25);
    wait_st(32'h2);
    far.flow(15);
    wait_st(32'h3);
    chk_bit("dose out", 1'b0, l2_o);
    rd_chk("count", ADDR_COUNT, 32'hffff, 32'd0);
    bus(1'b1, ADDR_MASK, 32'h0);
    chk_bit("irq", 1'b0, irq);
    bus(1'b1, ADDR_MASK, 32'h2);
    chk_bit("irq", 1'b1, irq);
    bus(1'b1, ADDR_IRQ, 32'hf);
    chk_bit("irq", 1'b0, irq);
    far.pulse(60);
    repeat (10) @(posedge clk_i);
    rd_chk("count", ADDR_COUNT, 32'hffff, 32'd20);
    bus(1'b1, ADDR_CORR, 32'hffffffe7);
    rd_chk("warn", ADDR_IRQ, 32'h4, 32'h4);
    rd_chk("corr", ADDR_CORR, 32'h3ffff, 32'h3ffed);
    bus(1'b1, ADDR_CORR, 32'd5);
    far.pulse(20);
    wait_st(32'h2);
    far.flow(10);
    far.pulse(20);
    wait_st(32'h1);
    far.pulse(20);
    wait_st(32'h2);
    far.flow(15);
    wait_st(32'h3);
    rd_chk("count", ADDR_COUNT, 32'hffff, 32'hfffb);
    bus(1'b1, ADDR_CTRL, 32'h0);
    chk_bit("dose oe", 1'b0, l2_oe);
    chk_bit("dose out", 1'b0, l2_o);
    chk_bit("ctl oe", 1'b0, l1_oe);
    bus(1'b1, ADDR_CTRL, 32'h1);
    far.pulse(20);
    wait_st(32'h2);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_bit("dose out", 1'b0, l2_o);
    rd_chk("ctrl", ADDR_CTRL, 32'h3, 32'h0);
    rd_chk("corr", ADDR_CORR, 32'h3ffff, 32'h1);
    final_report();
  end
endmodule : batch_dosing_controller_bench
